// >>> ext_oscillator_control.sv
// External oscillator control register, valid flag and divided clock
//
// Contract
// [RULE1] Offer external clock divided by eight
// [RULE2] Software keeps external below system frequency
// [RULE3] Divided clock synchronised to system clock
// [RULE4] Valid flag zero until settling elapses
// [RULE5] Software waits 1 ms before checking
// [RULE6] Software prepares pin latches before enabling
// [RULE7] Software polls valid before switching
// [RULE8] Software never switches clock early
// [RULE9] Tuning-fork crystals need extra settling
// [RULE10] Software picks range from crystal column
// [RULE11] Higher range improves RC accuracy
// [RULE12] Mode field selects oscillator type
module ext_oscillator_control
    import osc_pkg::*;
#(
    parameter int SETTLE_CYCLES = SETTLE_CYC // Settling count
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Oscillator pins, synchronous to clk
    input wire logic osc_pin_in,
    input wire logic osc_pin_out,
    input wire logic amp_ok,
    // Analog controls
    output logic osc_enable,
    output logic [2:0] ext_osc_mode_sel,
    output logic [2:0] ext_osc_freq_range,
    // Divided clock for timers and counter_array
    output logic ext_div8_clk,
    // Interrupt
    output logic irq
);

    // ==================================================
    // State
    // ==================================================
    typedef struct packed {
        logic [2:0] mode; // Oscillator mode
        logic [2:0] freq; // Frequency range
        logic [31:0] settle; // Settling counter
        logic vld; // Crystal stable flag
        logic [EV_W-1:0] stat; // Sticky events
        logic [EV_W-1:0] mask; // Event mask
        logic [1:0] sync; // Pin synchroniser
        logic last; // Previous synchronised level
        logic div_q; // Retimed divided clock
        logic [31:0] rdata; // Read data
        logic ack; // Access answered
        logic irq; // Interrupt level
        logic en; // Oscillator enable
    } ctl_state_t;

    ctl_state_t st_r; // Registered state
    ctl_state_t st_nxt; // Next state
    logic div_raw; // Divider output
    logic xtal; // Crystal mode active
    logic src; // Selected pin level
    logic [7:0] ctrl_rd; // Control read image

    // Crystal modes use the input pin; the others use the output pin
    assign xtal = (st_r.mode == MODE_XTAL) || (st_r.mode == MODE_OSC_PIN_OUT);
    assign src = xtal ? osc_pin_in : osc_pin_out;

    // Control register image; bit three reads zero
    always_comb begin
        ctrl_rd = CTRL_RESET;
        ctrl_rd[VLD_BIT] = st_r.vld;
        ctrl_rd[MODE_HI:MODE_LO] = st_r.mode;
        ctrl_rd[FREQ_HI:FREQ_LO] = st_r.freq;
    end

    // Divider on the synchronised edge
    osc_div8 u_div (
        .clk(clk),
        .nrst(nrst),
        .ext_edge(st_r.sync[1] & ~st_r.last),
        .halve((st_r.mode == MODE_CMOS2) || (st_r.mode == MODE_OSC_PIN_OUT)),
        .div_clk(div_raw)
    );

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        // Two-stage synchroniser, edge seen on second stage only
        st_nxt.sync = {st_r.sync[0], src}; // [RULE3]
        st_nxt.last = st_r.sync[1];
        st_nxt.div_q = (st_r.mode == MODE_OFF) ? 1'b0 : div_raw; // [RULE3]
        // Settling counter runs only in crystal modes with good amplitude
        if (!xtal || !amp_ok) begin
            st_nxt.settle = '0;
            st_nxt.vld = 1'b0; // [RULE12]
        end else if (st_r.settle < SETTLE_CYCLES) begin
            st_nxt.settle = st_r.settle + 32'h1;
            st_nxt.vld = 1'b0; // [RULE4]
        end else begin
            st_nxt.vld = 1'b1; // [RULE4]
        end
        // Bus access, answered one cycle after request
        if ((avs_read || avs_write) && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.rdata = '0;
            if (avs_write && avs_byteenable[0]) begin
                unique case (avs_address)
                    ADDR_CTRL: begin
                        st_nxt.mode = avs_writedata[MODE_HI:MODE_LO]; // [RULE12]
                        st_nxt.freq = avs_writedata[FREQ_HI:FREQ_LO]; // [RULE11]
                    end
                    ADDR_STAT: st_nxt.stat = st_r.stat & ~avs_writedata[EV_W-1:0];
                    ADDR_MASK: st_nxt.mask = avs_writedata[EV_W-1:0];
                    default: ;
                endcase
            end else if (avs_read) begin
                unique case (avs_address)
                    ADDR_CTRL: st_nxt.rdata = {24'h000000, ctrl_rd};
                    ADDR_STAT: st_nxt.rdata = {30'h0, st_r.stat};
                    ADDR_MASK: st_nxt.rdata = {30'h0, st_r.mask};
                    default: st_nxt.rdata = '0;
                endcase
            end
        end
        // Events set after the clear so that set wins
        if (st_nxt.vld && !st_r.vld) st_nxt.stat[EV_VLD_RISE] = 1'b1;
        if (!st_nxt.vld && st_r.vld) st_nxt.stat[EV_VLD_FALL] = 1'b1;
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
        // Enable registered so the pin comes straight from a flip-flop
        st_nxt.en = (st_nxt.mode != MODE_OFF); // [RULE12]
    end

    // Register state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = ~st_r.ack;
    assign osc_enable = st_r.en;
    assign ext_osc_mode_sel = st_r.mode;
    assign ext_osc_freq_range = st_r.freq;
    assign ext_div8_clk = st_r.div_q; // [RULE1]
    assign irq = st_r.irq;

endmodule // ext_oscillator_control

// >>> osc_pkg.sv
// Package: register map, field layout, modes and timing for the oscillator
package osc_pkg;

    // ==================================================
    // Register map (word index of each 32-bit register)
    // ==================================================
    localparam logic [7:0] ADDR_CTRL = 8'hB1; // Index of control register
    localparam logic [7:0] ADDR_STAT = 8'hB2; // Index of event status
    localparam logic [7:0] ADDR_MASK = 8'hB3; // Index of event mask
    localparam logic [7:0] CTRL_RESET = 8'h00; // Control reset value

    // ==================================================
    // Control field positions
    // ==================================================
    localparam int VLD_BIT = 7; // Crystal stable flag
    localparam int MODE_HI = 6; // Mode field top bit
    localparam int MODE_LO = 4; // Mode field low bit
    localparam int FREQ_HI = 2; // Frequency range top bit
    localparam int FREQ_LO = 0; // Frequency range low bit

    // ==================================================
    // Event bits
    // ==================================================
    localparam int EV_VLD_RISE = 0; // Crystal became stable
    localparam int EV_VLD_FALL = 1; // Crystal lost stability
    localparam int EV_W = 2; // Number of events

    // ==================================================
    // Oscillator modes
    // ==================================================
    localparam logic [2:0] MODE_OFF = 3'h0; // Oscillator off
    localparam logic [2:0] MODE_CMOS = 3'h2; // Digital clock
    localparam logic [2:0] MODE_CMOS2 = 3'h3; // Digital clock halved
    localparam logic [2:0] MODE_RC = 3'h4; // RC network
    localparam logic [2:0] MODE_CAP = 3'h5; // Capacitor
    localparam logic [2:0] MODE_XTAL = 3'h6; // Crystal
    localparam logic [2:0] MODE_OSC_PIN_OUT = 3'h7; // Crystal halved

    // ==================================================
    // Timing
    // ==================================================
    localparam int CLK_MHZ = 250; // System clock rate
    localparam int SETTLE_US = 1000; // Amplitude settling time
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ; // Least settle cycles
    localparam int DIV_RATIO = 8; // External clock divide ratio
    localparam logic [2:0] DIV_HALF = 3'h3; // Last count of a half period

endpackage : osc_pkg

// >>> osc_div8.sv
// Divides a synchronised external clock level by eight, or by sixteen when halve is set
module osc_div8
    import osc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // External clock edge, already in the clk domain
    input wire logic ext_edge,
    // Halve the source first
    input wire logic halve,
    // Divided clock level
    output logic div_clk
);

    // ==================================================
    // State
    // ==================================================
    typedef struct packed {
        logic pre; // Halving toggle
        logic [2:0] cnt; // Edge counter within half period
        logic out; // Divided level
    } div_state_t;

    div_state_t st_r; // Registered state
    div_state_t st_nxt; // Next state

    // Count rising edges; toggle output every four for a ratio of eight
    always_comb begin
        st_nxt = st_r;
        if (ext_edge) begin
            st_nxt.pre = ~st_r.pre;
            // Halved modes only count every second edge
            if (!halve || st_r.pre) begin
                if (st_r.cnt == DIV_HALF) begin
                    st_nxt.cnt = 3'h0;
                    st_nxt.out = ~st_r.out; // [RULE1]
                end else begin
                    st_nxt.cnt = st_r.cnt + 3'h1;
                end
            end
        end
    end

    // Register state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign div_clk = st_r.out;

endmodule // osc_div8

// >>> osc_ctrl_asserts.sv
// Port checker for the external oscillator control block
module osc_ctrl_asserts
    import osc_pkg::*;
#(parameter int SETTLE_CYCLES = SETTLE_CYC)(
    // Clock, reset and bus
    input wire logic clk, nrst, avs_read, avs_write, avs_waitrequest,
    input wire logic [7:0] avs_address,
    input wire logic [31:0] avs_readdata,
    // Oscillator side
    input wire logic amp_ok, osc_enable, ext_div8_clk,
    input wire logic [2:0] ext_osc_mode_sel, ext_osc_freq_range
);
    timeunit 1ns / 1ps;
    int run_r; // Cycles in a crystal mode with good amplitude
    logic rdone; // A read completes at this edge
    assign rdone = avs_read && !avs_waitrequest;
    // ==========================================
    // Settling counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) run_r <= 0;
        else run_r <= (ext_osc_mode_sel[2:1] == 2'b11 && amp_ok) ? run_r + 1 : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("access not answered");
    a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_enable_mode: assert property (osc_enable == (ext_osc_mode_sel != 3'h0))
        else $error("enable does not follow mode");
    a_div_off: assert property ((ext_osc_mode_sel == 3'h0)[*3] |-> !ext_div8_clk)
        else $error("divided clock runs while off");
    a_div_slow: assert property ($changed(ext_div8_clk) |=>
        ($stable(ext_div8_clk) || ext_osc_mode_sel == 3'h0)[*3]) else $error("div too fast");
    a_field_hold: assert property ($changed({ext_osc_mode_sel, ext_osc_freq_range})
        |-> $past(avs_write && avs_waitrequest && avs_address == ADDR_CTRL)) else $error("field moved");
    a_ctrl_read: assert property (rdone && avs_address == ADDR_CTRL |-> avs_readdata[6:0] ==
        {ext_osc_mode_sel, 1'b0, ext_osc_freq_range} && avs_readdata[31:8] == 24'h0) else $error("ctrl read");
    a_read_zero: assert property (rdone && (avs_address < ADDR_CTRL || avs_address > ADDR_MASK)
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_vld_settle: assert property (rdone && avs_address == ADDR_CTRL && avs_readdata[7]
        |-> run_r >= SETTLE_CYCLES - 2) else $error("valid before settling");
    c_vld: cover property (rdone && avs_address == ADDR_CTRL && avs_readdata[7]);
    c_div: cover property ($rose(ext_div8_clk));
    c_unmapped: cover property (rdone && avs_address > ADDR_MASK);
endmodule // osc_ctrl_asserts
bind ext_oscillator_control osc_ctrl_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_chk (.clk, .nrst,
    .avs_read, .avs_write, .avs_waitrequest, .avs_address, .avs_readdata, .amp_ok, .osc_enable,
    .ext_div8_clk, .ext_osc_mode_sel, .ext_osc_freq_range);

// >>> osc_network.sv
// Behavioural oscillator network at the pins
module osc_network #(parameter int HALF = 2)(
    // Clock, reset, mode and a stall from the bench
    input wire logic clk, nrst, stall,
    input wire logic [2:0] ext_osc_mode_sel,
    // Pin levels and amplitude detector
    output logic osc_pin_in, osc_pin_out, amp_ok
);
    timeunit 1ns / 1ps;
    int cnt; // Half period counter
    logic lvl, fast, xtal; // Source level, decoy level, crystal mode
    assign xtal = ext_osc_mode_sel[2:1] == 2'b11;
    // Used pin carries the source, the unused pin a faster decoy
    assign osc_pin_in = xtal ? lvl : fast;
    assign osc_pin_out = xtal ? fast : lvl;
    // Pins start low and are released before enabling
    // Source runs at or below the system rate; stall stops it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            lvl <= 1'b0;
            fast <= 1'b0;
            amp_ok <= 1'b0;
        end else begin
            fast <= !fast;
            amp_ok <= xtal && !stall;
            cnt <= (cnt == HALF - 1 || stall) ? 0 : cnt + 1;
            if (cnt == HALF - 1 && !stall) lvl <= !lvl;
        end
    end
endmodule // osc_network

// >>> tb_ext_oscillator_control.sv
// Bench for the external oscillator control block
module tb_ext_oscillator_control
    import osc_pkg::*;
;
    timeunit 1ns / 1ps;
    localparam int SETTLE = 20; // Short settling count
    logic clk, nrst, avs_read, avs_write, avs_waitrequest, stall, irq, osc_enable;
    logic osc_pin_in, osc_pin_out, amp_ok, ext_div8_clk;
    logic [2:0] ext_osc_mode_sel, ext_osc_freq_range;
    logic [7:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, rdv;
    logic [2:0] ml [6] = '{MODE_CMOS, MODE_CMOS2, MODE_RC, MODE_CAP, MODE_XTAL, MODE_OSC_PIN_OUT};
    int num_errors = 0, samples_checked = 0, cyc = 0;
    time t;
    ext_oscillator_control #(.SETTLE_CYCLES(SETTLE)) i_dut (.clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .osc_pin_in, .osc_pin_out, .amp_ok, .osc_enable,
        .ext_osc_mode_sel, .ext_osc_freq_range, .ext_div8_clk, .irq);
    osc_network #(.HALF(2)) i_net (.clk, .nrst, .stall, .ext_osc_mode_sel, .osc_pin_in,
        .osc_pin_out, .amp_ok);
    // Bus access: hold until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rdv);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    // Watchdog
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        {nrst, avs_read, avs_write, stall, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rdchk("ctrl reset", ADDR_CTRL, 32'h0);
        rdchk("mask reset", ADDR_MASK, 32'h0);
        bus(1'b1, ADDR_CTRL, 32'hFF);
        rdchk("ctrl all", ADDR_CTRL, 32'h77);
        avs_byteenable <= 4'hE;
        bus(1'b1, ADDR_CTRL, 32'h22);
        avs_byteenable <= 4'hF;
        bus(1'b1, 8'hB4, 32'hFF);
        rdchk("ctrl kept", ADDR_CTRL, 32'h77);
        rdchk("unmapped", 8'hB4, 32'h0);
        for (int r = 0; r < 8; r++) begin
            bus(1'b1, ADDR_CTRL, {24'h0, 1'b0, MODE_RC, 1'b0, 3'(r)});
            @(negedge clk);
            chk("range", 32'(r), {29'h0, ext_osc_freq_range});
        end
        $display("test fields done");
        bus(1'b1, ADDR_CTRL, 32'h67);
        rdchk("vld early", ADDR_CTRL, 32'h67);
        // Extra margin as for slow crystals; no early switch
        repeat (SETTLE + 10) @(posedge clk);
        rdchk("vld set", ADDR_CTRL, 32'hE7);
        rdchk("rise event", ADDR_STAT, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, ADDR_MASK, 32'h3);
        repeat (2) @(negedge clk);
        chk("irq on", 32'h1, {31'h0, irq});
        bus(1'b1, ADDR_STAT, 32'h1);
        repeat (2) @(negedge clk);
        chk("irq clear", 32'h0, {31'h0, irq});
        stall <= 1'b1;
        repeat (10) @(posedge clk);
        rdchk("vld lost", ADDR_CTRL, 32'h67);
        rdchk("fall event", ADDR_STAT, 32'h2);
        chk("irq fall", 32'h1, {31'h0, irq});
        bus(1'b1, ADDR_STAT, 32'h3);
        stall <= 1'b0;
        $display("test valid done");
        foreach (ml[i]) begin
            bus(1'b1, ADDR_CTRL, {24'h0, 1'b0, ml[i], 4'h0});
            repeat (2) @(posedge ext_div8_clk);
            t = $time;
            @(posedge ext_div8_clk);
            chk("div period", (&ml[i][1:0]) ? 64 : 32, 32'(($time - t) / 4));
        end
        bus(1'b1, ADDR_CTRL, 32'h0);
        repeat (4) @(negedge clk);
        chk("off", 32'h0, {30'h0, osc_enable, ext_div8_clk});
        $display("test divider done");
        summarize();
    end
endmodule // tb_ext_oscillator_control
